// File: sigma_delta_adc_control.sv
// sigma-delta converter control: divider, feedback flop, duty counter, registers
// assumes comparator outputs arrive synchronous to REF_CLK and one AHB-Lite master
`timescale 1ns/1ns
`default_nettype none
module sigma_delta_adc_control (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    // comparator results, one per analog input
    input wire logic [5:0] ANALOG_INPUT,
    // feedback pin to the external integrator
    output logic PWM_FEEDBACK_OUT,
    output logic PWM_FEEDBACK_OE,
    // interrupt
    output logic CONVERSION_DONE_IRQ
);
    sdadc_pkg::converter_setup_s setup_reg;
    logic [7:0] div_cnt_reg;
    logic [7:0] div_last;
    logic sample_tick;
    logic pwm_reg;
    logic pwm_next;
    logic oe_reg;
    logic [11:0] window_cnt_reg;
    logic [12:0] duty_cnt_reg;
    logic [12:0] result_reg;
    logic window_end;
    logic [12:0] final_count;
    logic [sdadc_pkg::EVT_WIDTH-1:0] evt_status_reg;
    logic [sdadc_pkg::EVT_WIDTH-1:0] evt_enable_reg;
    logic [sdadc_pkg::EVT_WIDTH-1:0] evt_set;
    logic irq_reg;
    logic [31:0] wr_addr_reg;
    logic wr_pending_reg;
    logic bus_take;
    logic [31:0] rd_next;
    logic selected_cmp;

    // sample clock divider; reserved codes stop the sample clock
    always_comb begin
        div_last = 8'h00;
        case (setup_reg.sample_clock_divider_select)
            4'h0: div_last = 8'h01;
            4'h2: div_last = 8'h03;
            4'h3: div_last = 8'h07;
            4'h4: div_last = 8'h0F;
            4'h5: div_last = 8'h1F;
            4'h6: div_last = 8'h3F;
            4'h7: div_last = 8'h7F;
            4'h8: div_last = 8'hFF;
            default: div_last = 8'h00;
        endcase
    end

    logic div_valid;
    assign div_valid = (setup_reg.sample_clock_divider_select == sdadc_pkg::CLKSEL_DIV2)
        || ((setup_reg.sample_clock_divider_select >= sdadc_pkg::CLKSEL_MIN)
        && (setup_reg.sample_clock_divider_select <= sdadc_pkg::CLKSEL_MAX));
    assign sample_tick = div_valid && (div_cnt_reg >= div_last);

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            div_cnt_reg <= 8'h00;
        end else if (!div_valid || sample_tick) begin
            div_cnt_reg <= 8'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    // input selector; codes above five feed a constant low
    always_comb begin
        selected_cmp = 1'b0;
        if (setup_reg.input_select <= sdadc_pkg::LAST_INPUT) begin
            selected_cmp = ANALOG_INPUT[setup_reg.input_select];
        end
    end

    assign pwm_next = sample_tick ? selected_cmp : pwm_reg;

    // feedback flop, captured once per sample cycle
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            pwm_reg <= 1'b0;
        end else begin
            pwm_reg <= pwm_next;
        end
    end

    // output buffer enable follows drive style and the value about to be driven
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            oe_reg <= 1'b0;
        end else begin
            case (setup_reg.feedback_drive_style)
                sdadc_pkg::DRIVE_BOTH: oe_reg <= 1'b1;
                sdadc_pkg::DRIVE_OFF: oe_reg <= 1'b0;
                sdadc_pkg::DRIVE_LOW_ONLY: oe_reg <= !pwm_next;
                sdadc_pkg::DRIVE_HIGH_ONLY: oe_reg <= pwm_next;
                default: oe_reg <= 1'b0;
            endcase
        end
    end

    // window and duty counters
    assign window_end = sample_tick && (window_cnt_reg == sdadc_pkg::WINDOW_LAST);
    assign final_count = duty_cnt_reg + {12'h000, pwm_reg};

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            window_cnt_reg <= 12'h000;
        end else if (sample_tick) begin
            window_cnt_reg <= window_cnt_reg + 12'h001;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            duty_cnt_reg <= 13'h0000;
        end else if (window_end) begin
            duty_cnt_reg <= 13'h0000;
        end else if (sample_tick && pwm_reg) begin
            duty_cnt_reg <= duty_cnt_reg + 13'h0001;
        end
    end

    // a full-window count is the over-range case and lands on bit 12
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            result_reg <= 13'h0000;
        end else if (window_end) begin
            result_reg <= final_count;
        end
    end

    // event sources
    always_comb begin
        evt_set = '0;
        evt_set[sdadc_pkg::EVT_DONE_BIT] = window_end;
        evt_set[sdadc_pkg::EVT_OVER_BIT] = window_end && final_count[12];
    end

    // ahb-lite: zero wait state, address phase captured, write in data phase
    assign bus_take = HSEL && HREADY && (HTRANS == sdadc_pkg::HTRANS_NONSEQ || HTRANS == 2'h3);

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            wr_pending_reg <= 1'b0;
            wr_addr_reg <= 32'h0000_0000;
        end else begin
            wr_pending_reg <= bus_take && HWRITE;
            if (bus_take) begin
                wr_addr_reg <= HADDR;
            end
        end
    end

    logic wr_setup;
    logic wr_clear;
    logic wr_enable;
    assign wr_setup = wr_pending_reg && (wr_addr_reg == sdadc_pkg::SETUP_ADDR);
    assign wr_clear = wr_pending_reg && (wr_addr_reg == sdadc_pkg::EVT_CLEAR_ADDR);
    assign wr_enable = wr_pending_reg && (wr_addr_reg == sdadc_pkg::EVT_ENABLE_ADDR);

    // next setup value, shared by the register, the interrupt and a read right after a write
    sdadc_pkg::converter_setup_s setup_next;
    always_comb begin
        setup_next = setup_reg;
        if (wr_setup) begin
            setup_next.input_select = HWDATA[sdadc_pkg::SEL_LSB+:3];
            setup_next.done_irq_enable = HWDATA[sdadc_pkg::ENABLE_BIT];
            setup_next.feedback_drive_style = HWDATA[sdadc_pkg::DRIVE_LSB+:2];
            setup_next.sample_clock_divider_select = HWDATA[sdadc_pkg::CLKSEL_LSB+:4];
        end
        // a done event in the clearing cycle keeps the flag set
        if (window_end) begin
            setup_next.done_pending_flag = 1'b1;
        end else if (wr_setup && HWDATA[sdadc_pkg::PENDING_BIT]) begin
            setup_next.done_pending_flag = 1'b0;
        end
    end

    // setup register; bits 31:11 are dropped and read as zero
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            setup_reg <= sdadc_pkg::SETUP_RESET;
        end else begin
            setup_reg <= setup_next;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            evt_status_reg <= '0;
        end else begin
            evt_status_reg <= evt_set
                | (evt_status_reg & ~(wr_clear ? HWDATA[sdadc_pkg::EVT_WIDTH-1:0] : '0));
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            evt_enable_reg <= '0;
        end else if (wr_enable) begin
            evt_enable_reg <= HWDATA[sdadc_pkg::EVT_WIDTH-1:0];
        end
    end

    // interrupt request from the next values, so it rises with the flag
    logic pending_next;
    logic [sdadc_pkg::EVT_WIDTH-1:0] status_next;
    logic en_next;
    logic [sdadc_pkg::EVT_WIDTH-1:0] evt_en_next;
    assign pending_next = setup_next.done_pending_flag;
    assign status_next = evt_set
        | (evt_status_reg & ~(wr_clear ? HWDATA[sdadc_pkg::EVT_WIDTH-1:0] : '0));
    assign en_next = setup_next.done_irq_enable;
    assign evt_en_next = wr_enable ? HWDATA[sdadc_pkg::EVT_WIDTH-1:0] : evt_enable_reg;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (pending_next && en_next) || (|(status_next & evt_en_next));
        end
    end

    // read data prepared in the address phase, shown in the data phase; next values
    // let a read right behind a write to the same register see the written data
    always_comb begin
        rd_next = 32'h0000_0000;
        case (HADDR)
            sdadc_pkg::SETUP_ADDR: rd_next = {21'h000000, setup_next};
            sdadc_pkg::RESULT_ADDR: rd_next = {19'h00000, result_reg};
            sdadc_pkg::EVT_STATUS_ADDR: rd_next = {30'h00000000, status_next};
            sdadc_pkg::EVT_ENABLE_ADDR: rd_next = {30'h00000000, evt_en_next};
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            HRDATA <= 32'h0000_0000;
        end else if (bus_take && !HWRITE) begin
            HRDATA <= rd_next;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    assign PWM_FEEDBACK_OUT = pwm_reg;
    assign PWM_FEEDBACK_OE = oe_reg;
    assign CONVERSION_DONE_IRQ = irq_reg;

    logic unused_ok;
    assign unused_ok = ^HSIZE;
endmodule : sigma_delta_adc_control
`default_nettype wire

// File: sdadc_pkg.sv
// constants, register map and field layouts of the sigma-delta converter control
// assumes a 32-bit AHB-Lite bus with one aligned word per register
// Notes on behaviour
// - count sample cycles with feedback output high
// - every 4096 cycles latch count, signal, restart
// - result is unsigned count 0 to 4096
// - thirteen-bit result once per window
// - feedback is flopped selected comparator, buffered out
// - selector bits 10:8 choose one of six
// - bit 7 pending flag, write one clears
// - bit 6 enables the done interrupt
// - bits 5:4 select feedback pin drive style
// - bits 3:0 select sample clock divider
// - result bit 12 over-range, 11:0 count
package sdadc_pkg;
    // printed offsets are word indices; byte address is four times the index
    localparam logic [31:0] SETUP_INDEX = 32'h0000_0402;
    localparam logic [31:0] RESULT_INDEX = 32'h0000_0406;
    localparam logic [31:0] SETUP_ADDR = SETUP_INDEX << 2;
    localparam logic [31:0] RESULT_ADDR = RESULT_INDEX << 2;
    localparam logic [31:0] EVT_STATUS_ADDR = 32'h0000_0020;
    localparam logic [31:0] EVT_CLEAR_ADDR = 32'h0000_0024;
    localparam logic [31:0] EVT_ENABLE_ADDR = 32'h0000_0028;

    localparam int WINDOW_LEN = 4096;
    localparam logic [11:0] WINDOW_LAST = 12'hFFF;
    localparam int NUM_INPUTS = 6;
    localparam logic [2:0] LAST_INPUT = 3'h5;

    // setup register field positions
    localparam int SEL_LSB = 8;
    localparam int PENDING_BIT = 7;
    localparam int ENABLE_BIT = 6;
    localparam int DRIVE_LSB = 4;
    localparam int CLKSEL_LSB = 0;

    // event bits
    localparam int EVT_DONE_BIT = 0;
    localparam int EVT_OVER_BIT = 1;
    localparam int EVT_WIDTH = 2;

    localparam logic [1:0] DRIVE_BOTH = 2'h0;
    localparam logic [1:0] DRIVE_OFF = 2'h1;
    localparam logic [1:0] DRIVE_LOW_ONLY = 2'h2;
    localparam logic [1:0] DRIVE_HIGH_ONLY = 2'h3;

    localparam logic [3:0] CLKSEL_DIV2 = 4'h0;
    localparam logic [3:0] CLKSEL_MIN = 4'h2;
    localparam logic [3:0] CLKSEL_MAX = 4'h8;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [2:0] input_select;
        logic done_pending_flag;
        logic done_irq_enable;
        logic [1:0] feedback_drive_style;
        logic [3:0] sample_clock_divider_select;
    } converter_setup_s;

    localparam converter_setup_s SETUP_RESET = '{
        input_select: 3'h0,
        done_pending_flag: 1'b0,
        done_irq_enable: 1'b0,
        feedback_drive_style: 2'h0,
        sample_clock_divider_select: 4'h0
    };
endpackage : sdadc_pkg

// File: sdadc_chk.sv
// port assertions for the sigma-delta converter control
// assumes it is bound to sigma_delta_adc_control
`timescale 1ns/1ns
`default_nettype none
module sdadc_chk (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic [31:0] HRDATA,
    input wire logic HRESP,
    // converter
    input wire logic [5:0] ANALOG_INPUT,
    input wire logic PWM_FEEDBACK_OUT,
    input wire logic PWM_FEEDBACK_OE,
    input wire logic CONVERSION_DONE_IRQ
);
    logic rd;
    assign rd = HSEL && HREADY && HTRANS[1] && !HWRITE;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    chk_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus stalled or erred");
    chk_reset_quiet: assert property ($fell(RST) |-> !PWM_FEEDBACK_OUT
        && !PWM_FEEDBACK_OE && !CONVERSION_DONE_IRQ) else $error("outputs active after reset");
    chk_tick_spacing: assert property ($changed(PWM_FEEDBACK_OUT) |=>
        $stable(PWM_FEEDBACK_OUT)) else $error("feedback changed on adjacent cycles");
    chk_rise_cause: assert property ($rose(PWM_FEEDBACK_OUT) |->
        $past(ANALOG_INPUT) != 6'h00) else $error("feedback rose with all inputs low");
    chk_fall_cause: assert property ($fell(PWM_FEEDBACK_OUT) |->
        $past(ANALOG_INPUT) != 6'h3F) else $error("feedback fell with all inputs high");
    chk_read_hold: assert property ($changed(HRDATA) |-> $past(rd))
        else $error("read data changed without a read");
    chk_result_range: assert property ($past(rd && HADDR == sdadc_pkg::RESULT_ADDR) |->
        HRDATA[31:13] == 19'h0 && (!HRDATA[12] || HRDATA[11:0] == 12'h000))
        else $error("result beyond full window");
    chk_unmapped_zero: assert property ($past(rd && HADDR == 32'h0000_1010) |->
        HRDATA == 32'h0000_0000) else $error("unmapped read not zero");
endmodule : sdadc_chk
`default_nettype wire

// File: sdadc_frontend_model.sv
// rc integrator and six comparators on the far side of the feedback pin
// assumes no pull on the pin: an undriven pin leaves the charge alone
`timescale 1ns/1ns
`default_nettype none
module sdadc_frontend_model (
    // clock
    input wire logic clk,
    // feedback pin
    input wire logic fb_out,
    input wire logic fb_oe,
    // per input: 0 low, 1 high, 2 tracks the integrator, 3 inverts the driven pin
    input wire logic [11:0] ch_mode,
    // comparator results
    output logic [5:0] cmp_out
);
    int charge = 0;
    initial cmp_out = 6'h00;
    always @(posedge clk) begin
        if (fb_oe && fb_out && charge < 4096) begin
            charge <= charge + 1;
        end else if (fb_oe && !fb_out && charge > -4096) begin
            charge <= charge - 1;
        end
        for (int i = 0; i < 6; i++) begin
            case (ch_mode[2*i+:2])
                2'h2: cmp_out[i] <= (charge < 0);
                2'h3: cmp_out[i] <= !fb_out;
                default: cmp_out[i] <= ch_mode[2*i];
            endcase
        end
    end
endmodule : sdadc_frontend_model
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the sigma-delta converter control
// assumes the design answers AHB-Lite with zero wait states
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rdata;
    logic hreadyout, hresp, fb_out, fb_oe, irq, last;
    logic [5:0] ain;
    logic [11:0] ch_mode = 12'h001;
    logic [3:0] oe_exp = 4'b1001;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int g, gap, mn;
    sigma_delta_adc_control i_dut (.REF_CLK(REF_CLK), .RST(RST), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp), .ANALOG_INPUT(ain),
        .PWM_FEEDBACK_OUT(fb_out), .PWM_FEEDBACK_OE(fb_oe), .CONVERSION_DONE_IRQ(irq));
    sdadc_frontend_model i_fe (.clk(REF_CLK), .fb_out(fb_out), .fb_oe(fb_oe),
        .ch_mode(ch_mode), .cmp_out(ain));
    initial begin
        forever #50 REF_CLK = ~REF_CLK;
    end
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 100000) begin
            error_cnt++;
            $display("CHECK FAILED at %0t ns: run timed out", $time);
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : check
    // one single AHB-Lite transfer; read data lands in rdata
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
        @(posedge REF_CLK);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= sdadc_pkg::HTRANS_NONSEQ;
        do @(posedge REF_CLK); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge REF_CLK); while (hreadyout !== 1'b1);
        rdata = hrdata;
    endtask : xfer
    function automatic logic [31:0] cfg(input logic [2:0] s, input logic e, input logic [1:0] d,
        input logic [3:0] k);
        return {21'h0, s, 1'b0, e, d, k};
    endfunction : cfg
    // wait for the done interrupt, read the result, then acknowledge it
    task automatic take(input logic [31:0] c, input logic [31:0] exp, input logic cmp);
        // let the previous acknowledge reach the interrupt flop first
        @(posedge REF_CLK);
        for (int n = 0; n < 9000 && irq !== 1'b1; n++) @(posedge REF_CLK);
        check({31'h0, irq}, 32'h1);
        xfer(sdadc_pkg::RESULT_ADDR, 1'b0, 32'h0);
        if (cmp) check(rdata, exp);
        xfer(sdadc_pkg::SETUP_ADDR, 1'b1, c | 32'h80);
    endtask : take
    task automatic irq_is(input logic v);
        repeat (2) @(posedge REF_CLK);
        check({31'h0, irq}, {31'h0, v});
    endtask : irq_is
    initial begin
        repeat (10) @(posedge REF_CLK);
        RST <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            xfer(sdadc_pkg::SETUP_ADDR, 1'b1, cfg(3'h0, 1'b1, s[1:0], 4'h0));
            repeat (4) @(posedge REF_CLK);
            check({31'h0, fb_oe}, {31'h0, oe_exp[s]});
        end
        check({31'h0, fb_out}, 32'h1);
        xfer(sdadc_pkg::SETUP_ADDR, 1'b0, 32'h0);
        check(rdata, cfg(3'h0, 1'b1, 2'h3, 4'h0));
        xfer(32'h0000_1010, 1'b0, 32'h0);
        check(rdata, 32'h0);
        $display("test drive styles done");
        take(cfg(3'h0, 1'b1, 2'h0, 4'h0), 32'h0FFF, 1'b1);
        take(cfg(3'h0, 1'b1, 2'h0, 4'h0), 32'h1000, 1'b1);
        xfer(sdadc_pkg::EVT_STATUS_ADDR, 1'b0, 32'h0);
        check(rdata, 32'h3);
        xfer(sdadc_pkg::EVT_ENABLE_ADDR, 1'b1, 32'h3);
        irq_is(1'b1);
        xfer(sdadc_pkg::EVT_ENABLE_ADDR, 1'b1, 32'h0);
        irq_is(1'b0);
        xfer(sdadc_pkg::EVT_ENABLE_ADDR, 1'b1, 32'h3);
        xfer(sdadc_pkg::EVT_CLEAR_ADDR, 1'b1, 32'h3);
        irq_is(1'b0);
        xfer(sdadc_pkg::EVT_STATUS_ADDR, 1'b0, 32'h0);
        check(rdata, 32'h0);
        xfer(sdadc_pkg::EVT_ENABLE_ADDR, 1'b1, 32'h0);
        $display("test windows done");
        xfer(sdadc_pkg::SETUP_ADDR, 1'b1, cfg(3'h1, 1'b0, 2'h0, 4'h0));
        for (int n = 0; n < 6000 && rdata[7] !== 1'b1; n++) xfer(sdadc_pkg::SETUP_ADDR, 1'b0, 0);
        check({31'h0, irq}, 32'h0);
        xfer(sdadc_pkg::SETUP_ADDR, 1'b1, cfg(3'h1, 1'b1, 2'h0, 4'h0));
        irq_is(1'b1);
        xfer(sdadc_pkg::SETUP_ADDR, 1'b0, 32'h0);
        check(rdata, cfg(3'h1, 1'b1, 2'h0, 4'h0) | 32'h80);
        xfer(sdadc_pkg::SETUP_ADDR, 1'b1, cfg(3'h1, 1'b1, 2'h0, 4'h0) | 32'h80);
        irq_is(1'b0);
        take(cfg(3'h1, 1'b1, 2'h0, 4'h0), 32'h0, 1'b1);
        ch_mode <= 12'h401;
        xfer(sdadc_pkg::SETUP_ADDR, 1'b1, cfg(3'h5, 1'b1, 2'h0, 4'h0));
        take(cfg(3'h5, 1'b1, 2'h0, 4'h0), 32'h0, 1'b0);
        take(cfg(3'h5, 1'b1, 2'h0, 4'h0), 32'h1000, 1'b1);
        $display("test pending and select done");
        // input 2 inverts the pin, so the feedback toggles on every sample tick
        ch_mode <= 12'h030;
        for (int k = 0; k < 10; k++) begin
            if (k == 1) continue;
            xfer(sdadc_pkg::SETUP_ADDR, 1'b1, cfg(3'h2, 1'b0, 2'h0, (k == 9) ? 4'h1 : k[3:0]));
            last = fb_out;
            g = 0;
            gap = 0;
            mn = 100000;
            for (int c = 0; c < 20000 && g < 6 && !(k == 9 && c > 600); c++) begin
                @(posedge REF_CLK);
                gap++;
                if (fb_out !== last) begin
                    last = fb_out;
                    if (g >= 3 && gap < mn) mn = gap;
                    g++;
                    gap = 0;
                end
            end
            if (k == 9) check(g, 0);
            else check(mn, (k == 0) ? 2 : (1 << k));
        end
        $display("test divider done");
        print_verdict();
    end
endmodule : tb_top
bind sigma_delta_adc_control sdadc_chk i_chk (.REF_CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HREADY, .HREADYOUT, .HRDATA, .HRESP, .ANALOG_INPUT, .PWM_FEEDBACK_OUT, .PWM_FEEDBACK_OE,
    .CONVERSION_DONE_IRQ);
`default_nettype wire
